/* File: design/mdpc_cfg.svh */
// Register map, field positions, reset values and timing of the mono DAC front end
// Behaviour
// - The DAC input sample is the left sample, the right sample or their average, picked by a two-bit field.
// - The data path accepts input sample rates anywhere from 8 kHz to 192 kHz.
// - The oversampling ratio is programmable from 1 to 1024.
// - Three interpolation filter types are offered for response, group delay and rate trade-offs.
// - The mono DAC channel powers up or down with a host-written control bit.
// - A read-only status bit reports DAC clipping and host writes to it have no effect.
// - A digital volume gain from -63.5 dB to +24 dB is applied to the DAC signal.
// - Three chains exist: filter A with IIR and six biquads, A with three biquads, B with IIR and six biquads.
// - Every coefficient of the IIR and of each biquad is writable by the host.
// - A control register selects the sources that feed the two output mixers and the headphone driver.
// - While the DAC runs, coefficient reads and writes are blocked unless adaptive mode is enabled.
// - Each coefficient is a 24-bit two's-complement value in 1.23 format.
`ifndef MDPC_CFG_SVH
`define MDPC_CFG_SVH
`define MDPC_CTRL_ADDR  8'h00
`define MDPC_OSR_ADDR   8'h04
`define MDPC_VOL_ADDR   8'h08
`define MDPC_ROUTE_ADDR 8'h0C
`define MDPC_FLAG_ADDR  8'h10
`define MDPC_IST_ADDR   8'h14
`define MDPC_IMSK_ADDR  8'h18
`define MDPC_CIDX_ADDR  8'h1C
`define MDPC_CDAT_ADDR  8'h20
`define MDPC_PWR_BIT    0
`define MDPC_SEL_LSB    1
`define MDPC_CHAIN_LSB  3
`define MDPC_MUTE_BIT   5
`define MDPC_ADAPT_BIT  6
`define MDPC_LOWLAT_BIT 7
`define MDPC_CLIP_BIT   0
`define MDPC_IRQ_CLIP   0
`define MDPC_IRQ_LOCK   1
`define MDPC_CTRL_RST   8'h00
`define MDPC_OSR_RST    10'h080
`define MDPC_VOL_RST    8'h00
`define MDPC_ROUTE_RST  8'h00
`define MDPC_COEF_ONE   24'h7FFFFF
`define MDPC_COEF_ZERO  24'h000000
`define MDPC_NCOEF      33
`define MDPC_VOL_MIN    (-127)
`define MDPC_VOL_MAX    48
`define MDPC_VOL_BIAS   132
`define MDPC_CLK_HZ     25000000
`define MDPC_FS_MIN_HZ  8000
`define MDPC_FS_MAX_HZ  192000
`define MDPC_PER_MAX    (`MDPC_CLK_HZ / `MDPC_FS_MIN_HZ)
`define MDPC_PER_W      12
`define MDPC_SH_A       3
`define MDPC_SH_B       0
`define MDPC_SH_C       1
`endif

/* File: design/mdpc_pkg.sv */
// Types shared by the mono DAC front end
package mdpc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_SEC, ST_VOL} mdpc_state_t;
  typedef enum logic [1:0] {
    chain_filter_a_iir_six_biquads,
    chain_filter_a_three_biquads,
    chain_filter_b_iir_six_biquads
  } mdpc_chain_t;
  typedef enum logic [1:0] {MONO_LEFT, MONO_RIGHT, MONO_AVG} mdpc_mono_t;
  typedef logic signed [23:0] mdpc_smp_t;
  typedef logic [4:0][23:0] mdpc_cset_t;

  // Wide signed product, operands widened first so nothing is lost
  function automatic logic signed [51:0] mdpc_mul(input logic signed [23:0] a, input logic signed [23:0] b);
    logic signed [51:0] wa;
    logic signed [51:0] wb;
    wa = a;
    wb = b;
    return wa * wb;
  endfunction

  // Saturate a wide value into one sample
  function automatic mdpc_smp_t mdpc_sat(input logic signed [51:0] v);
    if (v > 52'sh00000007FFFFF)
      return 24'h7FFFFF;
    else if (v < -52'sh0000000800000)
      return 24'h800000;
    else
      return v[23:0];
  endfunction
endpackage

/* File: design/mdpc_sec_if.sv */
// Carrier between the sequencer and one filter section
`timescale 1ns/100ps
interface mdpc_sec_if;
  import mdpc_pkg::*;
  logic       en;
  logic       clr;
  mdpc_smp_t  x;
  mdpc_smp_t  y;
  mdpc_cset_t c;
  modport sec (input en, input clr, input x, input c, output y);
  modport ctl (output en, output clr, output x, output c, input y);
endinterface

/* File: design/mdpc_section.sv */
// One IIR or biquad section with its delay line
`timescale 1ns/100ps
module mdpc_section #(
  parameter bit FIRST = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  mdpc_sec_if.sec   s
);
  import mdpc_pkg::*;

  typedef struct packed {
    mdpc_smp_t x1;
    mdpc_smp_t x2;
    mdpc_smp_t y1;
    mdpc_smp_t y2;
  } mdpc_dly_t;

  mdpc_dly_t          st;
  mdpc_dly_t          next_st;
  logic signed [51:0] sum;

  // Coefficients are 1.23, so the sum drops 23 fraction bits
  always_comb begin
    if (FIRST)
      sum = mdpc_mul(s.x, s.c[0]) + mdpc_mul(st.x1, s.c[1]) + mdpc_mul(st.y1, s.c[3]);
    else
      sum = mdpc_mul(s.x, s.c[0]) + (mdpc_mul(st.x1, s.c[1]) <<< 1) + mdpc_mul(st.x2, s.c[2])
          + (mdpc_mul(st.y1, s.c[3]) <<< 1) + mdpc_mul(st.y2, s.c[4]);
    s.y = mdpc_sat(sum >>> 23);
    next_st = st;
    if (s.clr)
      next_st = '0;
    else if (s.en) begin
      next_st.x1 = s.x;
      next_st.x2 = st.x1;
      next_st.y1 = s.y;
      next_st.y2 = st.y1;
    end
  end

  // Delay line advances once per sample
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      st <= '0;
    else
      st <= next_st;
  end
endmodule

/* File: design/mdpc_top.sv */
// Mono DAC digital front end: APB registers, mono mix, filter chain, volume, interpolation
`timescale 1ns/100ps
`include "mdpc_cfg.svh"
module mdpc_top (
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire logic [7:0]        paddr_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              sample_valid_i,
  input  wire mdpc_pkg::mdpc_smp_t left_i,
  input  wire mdpc_pkg::mdpc_smp_t right_i,
  output mdpc_pkg::mdpc_smp_t    dac_data_o,
  output logic                   dac_valid_o,
  output logic                   dac_power_o,
  output logic      [7:0]        mixer_route_o,
  output logic                   clip_o,
  output logic                   irq_o
);
  import mdpc_pkg::*;

  typedef struct packed {
    logic [7:0]                  ctrl;
    logic [9:0]                  osr;
    logic [7:0]                  vol;
    logic [7:0]                  route;
    logic [1:0]                  ist;
    logic [1:0]                  imsk;
    logic [5:0]                  cidx;
    logic [`MDPC_NCOEF-1:0][23:0] coef;
    mdpc_state_t                 state;
    logic [2:0]                  sec;
    mdpc_smp_t                   acc;
    mdpc_smp_t                   tgt;
    mdpc_smp_t                   out;
    logic                        clip;
    logic                        osv;
    logic                        short_run;
    logic [`MDPC_PER_W-1:0]      per_cnt;
    logic [`MDPC_PER_W-1:0]      period;
    logic [12:0]                 phase;
    logic [31:0]                 rdata;
  } mdpc_top_st_t;

  mdpc_top_st_t       st;
  mdpc_top_st_t       next_st;
  logic [1:0]         rsync;
  logic               rst_n;
  logic               pwr;
  logic               mute;
  logic               lock;
  mdpc_chain_t        chain;
  mdpc_mono_t         msel;
  logic               apb_set;
  logic               apb_acc;
  logic               apb_wr;
  logic               mapped;
  logic               coef_hit;
  logic               bad;
  logic [31:0]        rd_mux;
  logic signed [24:0] lr_sum;
  mdpc_smp_t          mono;
  logic               start;
  logic               last_sec;
  mdpc_smp_t          ysec [7];
  mdpc_smp_t          vol_out;
  logic               vol_clip;
  logic signed [51:0] prod;
  logic [16:0]        frac;
  logic [10:0]        osr_eff;
  logic [12:0]        phase_sum;
  logic               tick;
  logic signed [24:0] diff;
  logic [1:0]         ev;

  // Reset is released through two flops so every flop leaves reset on the same edge
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i)
      rsync <= 2'h0;
    else
      rsync <= {rsync[0], 1'b1};
  end
  assign rst_n = rsync[1];

  // Control decode
  assign pwr   = st.ctrl[`MDPC_PWR_BIT];
  assign mute  = st.ctrl[`MDPC_MUTE_BIT];
  assign chain = mdpc_chain_t'(st.ctrl[`MDPC_CHAIN_LSB +: 2]);
  assign msel  = mdpc_mono_t'(st.ctrl[`MDPC_SEL_LSB +: 2]);
  assign lock  = pwr & ~st.ctrl[`MDPC_ADAPT_BIT];

  // APB decode; zero wait states, so pready is a constant high
  assign apb_set  = psel_i & ~penable_i;
  assign apb_acc  = psel_i & penable_i;
  assign apb_wr   = apb_acc & pwrite_i;
  assign coef_hit = paddr_i == `MDPC_CDAT_ADDR;
  assign bad      = ~mapped | (coef_hit & (lock | (st.cidx >= 6'(`MDPC_NCOEF))));
  assign pready_o  = 1'b1;
  assign pslverr_o = apb_acc & bad;
  assign prdata_o  = st.rdata;

  // Read mux, sampled in the setup cycle; blocked coefficient reads return zero
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0;
    case (paddr_i)
      `MDPC_CTRL_ADDR:  rd_mux = {24'h0, st.ctrl};
      `MDPC_OSR_ADDR:   rd_mux = {22'h0, st.osr};
      `MDPC_VOL_ADDR:   rd_mux = {24'h0, st.vol};
      `MDPC_ROUTE_ADDR: rd_mux = {24'h0, st.route};
      `MDPC_FLAG_ADDR:  rd_mux = {31'h0, st.clip};
      `MDPC_IST_ADDR:   rd_mux = {30'h0, st.ist};
      `MDPC_IMSK_ADDR:  rd_mux = {30'h0, st.imsk};
      `MDPC_CIDX_ADDR:  rd_mux = {26'h0, st.cidx};
      `MDPC_CDAT_ADDR: begin
        if (!lock && st.cidx < 6'(`MDPC_NCOEF))
          rd_mux = {8'h0, st.coef[st.cidx]};
      end
      default:          mapped = 1'b0;
    endcase
  end

  // Mono source: the halved sum is one bit wider first, so it never wraps
  assign lr_sum = $signed({left_i[23], left_i}) + $signed({right_i[23], right_i});
  always_comb begin
    case (msel)
      MONO_LEFT:  mono = left_i;
      MONO_RIGHT: mono = right_i;
      MONO_AVG:   mono = lr_sum[24:1];
      default:    mono = left_i;
    endcase
  end

  // A new sample starts the chain only when powered and idle
  assign start = sample_valid_i & pwr & (st.state == ST_IDLE);

  // Filter sections: index 0 is the IIR, 1 to 6 are the biquads
  for (genvar k = 0; k < 7; k++) begin : g_sec
    mdpc_sec_if sif ();
    assign sif.en  = (st.state == ST_SEC) && (st.sec == 3'(k));
    assign sif.clr = ~pwr;
    assign sif.x   = st.acc;
    if (k == 0) begin : g_iir
      assign sif.c = {`MDPC_COEF_ZERO, st.coef[2], `MDPC_COEF_ZERO, st.coef[1], st.coef[0]};
    end else begin : g_bq
      assign sif.c = {st.coef[5*k+2], st.coef[5*k+1], st.coef[5*k], st.coef[5*k-1], st.coef[5*k-2]};
    end
    assign ysec[k] = sif.y;
    mdpc_section #(
      .FIRST(k == 0)
    ) u_sec (
      .clk_i  (clk_i),
      .rst_n_i(rst_n),
      .s      (sif)
    );
  end

  // Chain length is latched at start, so a chain change never cuts or stretches the sample in flight
  assign last_sec = st.short_run ? (st.sec == 3'h3) : (st.sec == 3'h6);

  // Volume: 0.5 dB steps taken as 1/12 octave, an octave shift plus a table fraction
  always_comb begin
    int vv;
    int q;
    int r;
    vv = int'($signed(st.vol)) + `MDPC_VOL_BIAS;
    q  = vv / 12;
    r  = vv % 12;
    case (r)
      0:       frac = 17'h08000;
      1:       frac = 17'h0879C;
      2:       frac = 17'h08F5D;
      3:       frac = 17'h09838;
      4:       frac = 17'h0A145;
      5:       frac = 17'h0AADC;
      6:       frac = 17'h0B505;
      7:       frac = 17'h0BFC9;
      8:       frac = 17'h0CB30;
      9:       frac = 17'h0D745;
      10:      frac = 17'h0E412;
      11:      frac = 17'h0F1A2;
      default: frac = 17'h08000;
    endcase
    prod = mdpc_mul(st.acc, {7'h00, frac}) >>> 15;
    if (q >= 11)
      prod = prod <<< (q - 11);
    else
      prod = prod >>> (11 - q);
    vol_out  = mdpc_sat(prod);
    vol_clip = (52'(vol_out) != prod);
  end

  // Fractional divider: osr_eff ticks per measured input period
  assign osr_eff   = (st.osr == 10'h000) ? 11'h400 : {1'b0, st.osr};
  assign phase_sum = st.phase + {2'h0, osr_eff};
  assign tick      = pwr & (st.period != '0) & (phase_sum >= {1'b0, st.period});
  assign diff      = $signed({st.tgt[23], st.tgt}) - $signed({st.out[23], st.out});

  // Events for the interrupt status
  assign ev[`MDPC_IRQ_CLIP] = (st.state == ST_VOL) & vol_clip;
  assign ev[`MDPC_IRQ_LOCK] = apb_acc & coef_hit & lock;

  // Next state of registers, sequencer and output stage
  always_comb begin
    next_st     = st;
    next_st.osv = 1'b0;
    if (apb_set)
      next_st.rdata = rd_mux;
    // Register writes take effect at the access edge only
    if (apb_wr && !bad) begin
      case (paddr_i)
        `MDPC_CTRL_ADDR:  next_st.ctrl = pwdata_i[7:0];
        `MDPC_OSR_ADDR:   next_st.osr = pwdata_i[9:0];
        `MDPC_VOL_ADDR: begin
          if ($signed(pwdata_i[7:0]) < 8'(`MDPC_VOL_MIN))
            next_st.vol = 8'(`MDPC_VOL_MIN);
          else if ($signed(pwdata_i[7:0]) > 8'(`MDPC_VOL_MAX))
            next_st.vol = 8'(`MDPC_VOL_MAX);
          else
            next_st.vol = pwdata_i[7:0];
        end
        `MDPC_ROUTE_ADDR: next_st.route = pwdata_i[7:0];
        `MDPC_IMSK_ADDR:  next_st.imsk = pwdata_i[1:0];
        `MDPC_CIDX_ADDR:  next_st.cidx = pwdata_i[5:0];
        `MDPC_CDAT_ADDR:  next_st.coef[st.cidx] = pwdata_i[23:0];
        default:          next_st.ctrl = st.ctrl;
      endcase
    end
    // Write one to clear; a new event in the same cycle wins
    if (apb_wr && paddr_i == `MDPC_IST_ADDR)
      next_st.ist = st.ist & ~pwdata_i[1:0];
    next_st.ist = next_st.ist | ev;
    // Period counter measures the input rate; 12 bits hold an 8 kHz period
    if (sample_valid_i) begin
      next_st.period  = st.per_cnt + 1'b1;
      next_st.per_cnt = '0;
    end else if (st.per_cnt != '1) begin
      next_st.per_cnt = st.per_cnt + 1'b1;
    end
    // Sample sequencer, one section per clock
    case (st.state)
      ST_IDLE: begin
        if (start) begin
          next_st.acc   = mono;
          next_st.sec   = (chain == chain_filter_a_three_biquads) ? 3'h1 : 3'h0;
          next_st.short_run = (chain == chain_filter_a_three_biquads);
          next_st.state = ST_SEC;
        end
      end
      ST_SEC: begin
        next_st.acc = ysec[st.sec];
        if (last_sec)
          next_st.state = ST_VOL;
        else
          next_st.sec = st.sec + 3'h1;
      end
      ST_VOL: begin
        next_st.tgt   = mute ? 24'h000000 : vol_out;
        next_st.clip  = vol_clip;
        next_st.state = ST_IDLE;
      end
      default: next_st.state = ST_IDLE;
    endcase
    // Interpolation at the oversampled rate; the low-latency type overrides the chain
    if (tick) begin
      next_st.phase = phase_sum - {1'b0, st.period};
      next_st.osv   = 1'b1;
      if (st.ctrl[`MDPC_LOWLAT_BIT])
        next_st.out = st.out + 24'(diff >>> `MDPC_SH_C);
      else if (chain == chain_filter_b_iir_six_biquads)
        next_st.out = st.out + 24'(diff >>> `MDPC_SH_B);
      else
        next_st.out = st.out + 24'(diff >>> `MDPC_SH_A);
    end else if (pwr) begin
      next_st.phase = phase_sum;
    end
    // Powered down: drop the sample in flight and silence the output
    if (!pwr) begin
      next_st.state = ST_IDLE;
      next_st.out   = '0;
      next_st.tgt   = '0;
      next_st.phase = '0;
    end
  end

  // State register; unity N0 coefficients make every section flat after reset
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st       <= '0;
      st.ctrl  <= `MDPC_CTRL_RST;
      st.osr   <= `MDPC_OSR_RST;
      st.vol   <= `MDPC_VOL_RST;
      st.route <= `MDPC_ROUTE_RST;
      for (int i = 0; i < `MDPC_NCOEF; i++) begin
        if (i == 0 || (i >= 3 && (i - 3) % 5 == 0))
          st.coef[i] <= `MDPC_COEF_ONE;
        else
          st.coef[i] <= `MDPC_COEF_ZERO;
      end
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state
  assign dac_data_o    = st.out;
  assign dac_valid_o   = st.osv;
  assign dac_power_o   = pwr;
  assign mixer_route_o = st.route;
  assign clip_o        = st.clip;
  assign irq_o         = |(st.ist & st.imsk);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n);

  mono_left_a: assert property (start && msel == MONO_LEFT |=> st.acc == $past(left_i))
    else $error("mono left sample not taken");
  mono_avg_a: assert property (start && msel == MONO_AVG |=>
      st.acc == 24'(($signed({$past(left_i[23]), $past(left_i)}) + $signed({$past(right_i[23]), $past(right_i)})) >>> 1))
    else $error("mono average wrong");
  short_chain_a: assert property (start && chain == chain_filter_a_three_biquads |-> ##4 (st.state == ST_VOL || !pwr))
    else $error("three biquad chain length wrong");
  long_chain_a: assert property (start && chain == chain_filter_b_iir_six_biquads |-> ##8 (st.state == ST_VOL || !pwr))
    else $error("six biquad chain length wrong");
  power_down_a: assert property (!pwr |=> st.state == ST_IDLE && dac_data_o == '0)
    else $error("powered down path not silent");
  coef_lock_a: assert property (apb_wr && coef_hit && lock |=> $stable(st.coef))
    else $error("locked coefficient written");
  coef_write_a: assert property (apb_wr && coef_hit && !bad |=> st.coef[$past(st.cidx)] == $past(pwdata_i[23:0]))
    else $error("coefficient write lost");
  clip_ro_a: assert property (apb_wr && paddr_i == `MDPC_FLAG_ADDR && st.state != ST_VOL |=> $stable(st.clip))
    else $error("clip flag changed by write");
  mute_zero_a: assert property (st.state == ST_VOL && mute && pwr |=> st.tgt == '0)
    else $error("mute did not zero the sample");
  vol_range_a: assert property (apb_wr && paddr_i == `MDPC_VOL_ADDR |=>
      $signed(st.vol) >= 8'(`MDPC_VOL_MIN) && $signed(st.vol) <= 8'(`MDPC_VOL_MAX))
    else $error("volume out of range");

  short_chain_c: cover property (start && chain == chain_filter_a_three_biquads);
  long_chain_c: cover property (start && chain == chain_filter_a_iir_six_biquads);
  clip_event_c: cover property (ev[`MDPC_IRQ_CLIP]);
  lock_refuse_c: cover property (ev[`MDPC_IRQ_LOCK]);
endmodule

/* File: verification/mdpc_src_model.sv */
// Audio sample source that feeds left/right pairs into the DAC front end
`timescale 1ns/100ps
module mdpc_src_model (
  input  wire logic                clk_i,
  input  wire logic                en_i,
  input  wire logic [11:0]         period_i,
  input  wire mdpc_pkg::mdpc_smp_t lset_i,
  input  wire mdpc_pkg::mdpc_smp_t rset_i,
  output logic                     valid_o,
  output mdpc_pkg::mdpc_smp_t      left_o,
  output mdpc_pkg::mdpc_smp_t      right_o
);
  import mdpc_pkg::*;
  logic [11:0] cnt;
  initial begin
    cnt = 12'h000;
    valid_o = 1'b0;
    left_o = 24'h000000;
    right_o = 24'h000000;
  end
  // One pair per frame; data lines flip between frames so stale values never look valid
  always @(posedge clk_i) begin
    if (en_i && cnt >= period_i - 12'h001) begin
      cnt <= 12'h000;
      valid_o <= 1'b1;
      left_o <= lset_i;
      right_o <= rset_i;
    end else begin
      cnt <= en_i ? cnt + 12'h001 : 12'h000;
      valid_o <= 1'b0;
      left_o <= ~left_o;
      right_o <= ~right_o;
    end
  end
endmodule

/* File: verification/mono_dac_processing_control_tb_top.sv */
// Self-checking bench of the mono DAC front end
`timescale 1ns/100ps
`include "mdpc_cfg.svh"
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin err_count++; $display("unexpected %s exp %h got %h", nm, ex, gt); end end
module mono_dac_processing_control_tb_top;
  import mdpc_pkg::*;
  logic        clk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, sv, en;
  logic        dac_valid_o, dac_power_o, clip_o, irq_o, e;
  logic [7:0]  paddr_i, mixer_route_o;
  logic [31:0] pwdata_i, prdata_o, q;
  logic [11:0] period;
  mdpc_smp_t   left_i, right_i, dac_data_o, lset, rset;
  int          err_count, tests_run, c;
  logic [7:0]  ctl_t[4] = '{8'h11, 8'h13, 8'h15, 8'h15};
  logic [23:0] l_t[4] = '{24'h200001, 24'h200001, 24'h200001, 24'h7FFFFF};
  logic [23:0] r_t[4] = '{24'hE00000, 24'hE00000, 24'hE00000, 24'h7FFFFF};
  logic [7:0]  chn_t[4] = '{8'h01, 8'h09, 8'h11, 8'h81};

  mdpc_top dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .sample_valid_i(sv), .left_i(left_i), .right_i(right_i), .dac_data_o(dac_data_o), .dac_valid_o(dac_valid_o),
    .dac_power_o(dac_power_o), .mixer_route_o(mixer_route_o), .clip_o(clip_o), .irq_o(irq_o));
  mdpc_src_model src_u (.clk_i(clk_i), .en_i(en), .period_i(period), .lset_i(lset), .rset_i(rset),
    .valid_o(sv), .left_o(left_i), .right_o(right_i));

  task automatic end_sim();
    $display("tests_run %0d err_count %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One APB transfer; holds the request until pready is seen high at a rising edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    paddr_i <= a;
    pwrite_i <= w;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      end_sim();
    end
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    // Outputs launched at the access edge settle before any caller looks at them
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
    apb(a, 1'b1, d);
    `CHK("pslverr", xe, e)
    `CHK("pready_o", 1'b1, pready_o)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(a, 1'b0, 32'h00000000);
    `CHK("prdata", x, q)
    `CHK("pslverr", xe, e)
  endtask
  // Bounded wait for k output pulses; a hang counts as a mismatch
  task automatic wait_valid(input int k);
    int n;
    n = 0;
    repeat (k) begin
      do begin
        @(posedge clk_i);
        #1;
        n++;
      end while (dac_valid_o !== 1'b1 && n < 20000);
    end
    if (n >= 20000) begin
      err_count++;
      end_sim();
    end
  endtask
  task automatic count_valid(input int cyc);
    c = 0;
    repeat (cyc) begin
      @(posedge clk_i);
      #1;
      if (dac_valid_o === 1'b1) c++;
    end
  endtask

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  initial begin
    {nrst_i, psel_i, penable_i, pwrite_i, en} = 5'h00;
    paddr_i = 8'h00;
    pwdata_i = 32'h00000000;
    period = 12'h082;
    lset = 24'h000000;
    rset = 24'h000000;
    err_count = 0;
    tests_run = 0;
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    // Reset values, plain registers and refused accesses
    rd(`MDPC_CTRL_ADDR, 32'h00000000, 1'b0);
    rd(`MDPC_OSR_ADDR, 32'h00000080, 1'b0);
    rd(`MDPC_VOL_ADDR, 32'h00000000, 1'b0);
    wr(`MDPC_ROUTE_ADDR, 32'h000000A5, 1'b0);
    rd(`MDPC_ROUTE_ADDR, 32'h000000A5, 1'b0);
    `CHK("mixer_route_o", 8'hA5, mixer_route_o)
    wr(`MDPC_VOL_ADDR, 32'h0000007F, 1'b0);
    rd(`MDPC_VOL_ADDR, 32'h00000030, 1'b0);
    wr(`MDPC_VOL_ADDR, 32'h00000080, 1'b0);
    rd(`MDPC_VOL_ADDR, 32'h00000081, 1'b0);
    wr(`MDPC_OSR_ADDR, 32'h000003FF, 1'b0);
    rd(`MDPC_OSR_ADDR, 32'h000003FF, 1'b0);
    wr(`MDPC_FLAG_ADDR, 32'h00000001, 1'b0);
    rd(`MDPC_FLAG_ADDR, 32'h00000000, 1'b0);
    rd(8'h24, 32'h00000000, 1'b1);
    wr(8'h24, 32'h00000001, 1'b1);
    $display("test registers done");
    // Coefficient bank while powered down
    wr(`MDPC_CIDX_ADDR, 32'h00000003, 1'b0);
    rd(`MDPC_CDAT_ADDR, 32'h007FFFFF, 1'b0);
    wr(`MDPC_CIDX_ADDR, 32'h00000020, 1'b0);
    wr(`MDPC_CDAT_ADDR, 32'h00ABCDEF, 1'b0);
    rd(`MDPC_CDAT_ADDR, 32'h00ABCDEF, 1'b0);
    wr(`MDPC_CDAT_ADDR, 32'h00000000, 1'b0);
    wr(`MDPC_CIDX_ADDR, 32'h00000021, 1'b0);
    rd(`MDPC_CDAT_ADDR, 32'h00000000, 1'b1);
    // Locked access while running, lock interrupt masked then unmasked
    wr(`MDPC_CIDX_ADDR, 32'h00000020, 1'b0);
    wr(`MDPC_CTRL_ADDR, 32'h00000001, 1'b0);
    `CHK("dac_power_o", 1'b1, dac_power_o)
    rd(`MDPC_CDAT_ADDR, 32'h00000000, 1'b1);
    `CHK("irq_o", 1'b0, irq_o)
    wr(`MDPC_IMSK_ADDR, 32'h00000002, 1'b0);
    `CHK("irq_o", 1'b1, irq_o)
    rd(`MDPC_IST_ADDR, 32'h00000002, 1'b0);
    wr(`MDPC_IST_ADDR, 32'h00000002, 1'b0);
    `CHK("irq_o", 1'b0, irq_o)
    wr(`MDPC_CTRL_ADDR, 32'h00000041, 1'b0);
    wr(`MDPC_CDAT_ADDR, 32'h00000000, 1'b0);
    $display("test coefficients done");
    // Mono selection, wide average and mute through the hold interpolator
    wr(`MDPC_OSR_ADDR, 32'h00000020, 1'b0);
    en = 1'b1;
    for (int i = 0; i < 5; i++) begin
      lset = (i < 4) ? l_t[i] : 24'h200000;
      rset = (i < 4) ? r_t[i] : 24'h200000;
      wr(`MDPC_CTRL_ADDR, (i < 4) ? {24'h0, ctl_t[i]} : 32'h00000035, 1'b0);
      wait_valid(70);
      `CHK("dac sign", (i == 1) ? 1'b1 : 1'b0, dac_data_o[23])
      `CHK("dac zero", (i == 2 || i == 4) ? 1'b1 : 1'b0, dac_data_o === 24'h000000)
    end
    // Every chain and interpolation type passes a positive left sample
    for (int i = 0; i < 4; i++) begin
      wr(`MDPC_CTRL_ADDR, {24'h0, chn_t[i]}, 1'b0);
      wait_valid(70);
      `CHK("chain positive", 1'b1, dac_data_o[23] === 1'b0 && dac_data_o !== 24'h000000)
    end
    $display("test data path done");
    // Clipping at full gain sets the read-only flag and its event bit
    lset = 24'h7FFFFF;
    wr(`MDPC_IMSK_ADDR, 32'h00000001, 1'b0);
    wr(`MDPC_VOL_ADDR, 32'h00000030, 1'b0);
    wait_valid(70);
    `CHK("clip_o", 1'b1, clip_o)
    rd(`MDPC_FLAG_ADDR, 32'h00000001, 1'b0);
    `CHK("irq_o", 1'b1, irq_o)
    wr(`MDPC_VOL_ADDR, 32'h00000000, 1'b0);
    $display("test clipping done");
    // Output pulse count follows the ratio at both rate extremes
    repeat (400) @(posedge clk_i);
    count_valid(1300);
    `CHK("pulses 192k", 1'b1, c >= 319 && c <= 321)
    period = 12'hC35;
    wr(`MDPC_OSR_ADDR, 32'h00000080, 1'b0);
    repeat (9400) @(posedge clk_i);
    count_valid(6250);
    `CHK("pulses 8k", 1'b1, c >= 255 && c <= 257)
    wr(`MDPC_CTRL_ADDR, 32'h00000000, 1'b0);
    count_valid(6400);
    `CHK("pulses off", 0, c)
    `CHK("dac_data_o off", 24'h000000, dac_data_o)
    $display("test rates and power done");
    end_sim();
  end
endmodule
